// file: hw/poci_top.sv
// Eight discrete inputs and eight discrete outputs with two pulse
// train outputs and two event counters, reached by bit and word accesses.
// Assumes din pins are asynchronous and mode straps are on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module poci_top #(
	parameter int unsigned UNIT_CYCLES = poci_pkg::UNIT_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  din,
	input  wire logic [1:0]  cfg_out_pulse,
	input  wire logic [1:0]  cfg_in_count,
	input  wire logic        acc_req,
	input  wire logic        acc_we,
	input  wire logic [1:0]  acc_space,
	input  wire logic [15:0] acc_addr,
	input  wire logic [15:0] acc_wdata,
	output logic      [7:0]  dout,
	output logic             acc_ack,
	output logic             acc_err,
	output logic      [15:0] acc_rdata
);
	// The prescaler is 16 bits wide and needs at least two steps
	if (UNIT_CYCLES < 2 || UNIT_CYCLES > 65535) begin : g_bad_unit
		$error("UNIT_CYCLES out of range");
	end

	logic [7:0]  din_m_q, din_s_q, din_p_q;
	logic [7:0]  ostate_q, ostate_d, dout_q, dout_d;
	logic        ack_q, err_q;
	logic [15:0] rdata_q;
	logic [1:0]  prun, crun, ovf, plvl;
	wire  [7:0]  ifunc = {6'h00, cfg_in_count};
	wire  [7:0]  ofunc = {6'h00, cfg_out_pulse};

	// Access decode
	wire sp_c = acc_space == poci_pkg::SP_COIL;
	wire sp_d = acc_space == poci_pkg::SP_DIN;
	wire sp_h = acc_space == poci_pkg::SP_HOLD;
	wire sp_i = acc_space == poci_pkg::SP_IREG;
	wire rd_ok = (sp_c && acc_addr < poci_pkg::C_END)
		|| (sp_d && acc_addr < poci_pkg::D_END)
		|| (sp_h && acc_addr < poci_pkg::H_END)
		|| (sp_i && acc_addr < poci_pkg::I_END);
	// Mode bits and input state are never writable
	wire wr_ok = (sp_c && acc_addr < poci_pkg::C_END)
		|| (sp_h && acc_addr < poci_pkg::H_END);
	wire ok = acc_we ? wr_ok : rd_ok;
	wire cw = acc_req && acc_we && sp_c;
	wire hw = acc_req && acc_we && sp_h;
	wire osw_we  = hw && acc_addr == poci_pkg::H_OSW;
	wire prw_we  = hw && acc_addr == poci_pkg::H_PRUN;
	wire crw_we  = hw && acc_addr == poci_pkg::H_CRUN;
	wire clrw_we = hw && acc_addr == poci_pkg::H_CLR;

	// Input synchroniser and edge history
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			din_m_q <= 8'h00;
			din_s_q <= 8'h00;
			din_p_q <= 8'h00;
		end else begin
			din_m_q <= din;
			din_s_q <= din_m_q;
			din_p_q <= din_s_q;
		end
	end

	// Output state bits, per coil or whole word
	for (genvar j = 0; j < 8; j++) begin : g_os
		wire bit_we = cw && acc_addr == 16'(poci_pkg::C_OSTATE + j);
		assign ostate_d[j] = bit_we ? acc_wdata[0]
			: osw_we ? acc_wdata[j] : ostate_q[j];
		if (j < 2) begin : g_m
			assign dout_d[j] = ofunc[j] ? plvl[j] : ostate_q[j];
		end else begin : g_p
			assign dout_d[j] = ostate_q[j];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ostate_q <= 8'h00;
			dout_q   <= 8'h00;
		end else begin
			ostate_q <= ostate_d;
			dout_q   <= dout_d;
		end
	end

	// Pulse train channels
	for (genvar i = 0; i < 2; i++) begin : g_pl
		poci_pkg::poci_phase_t ph_q, ph_d;
		logic [15:0] high_q, low_q, pre_q, units_q;
		logic [31:0] total_q, done_q;
		logic        run_q;
		wire bit_we = cw && acc_addr == 16'(poci_pkg::C_PRUN + i);
		wire thi_we = hw && acc_addr == 16'(poci_pkg::H_TOTAL + 2 * i);
		wire tlo_we = hw && acc_addr == 16'(poci_pkg::H_TOTAL + 2 * i + 1);
		wire hi_we  = hw && acc_addr == 16'(poci_pkg::H_HIGH + i);
		wire lo_we  = hw && acc_addr == 16'(poci_pkg::H_LOW + i);
		wire go     = run_q && ofunc[i];
		wire tick   = pre_q == 16'(UNIT_CYCLES - 1);
		wire last   = tick && units_q <= 16'h0001;
		wire [31:0] done_n = done_q + 32'h00000001;
		wire fin    = ph_q == poci_pkg::PH_LOW && last && go
			&& total_q != 32'h00000000 && done_n >= total_q;
		wire [15:0] hload = high_q == 16'h0000 ? 16'h0001 : high_q;
		wire [15:0] lload = low_q == 16'h0000 ? 16'h0001 : low_q;
		assign plvl[i] = ph_q == poci_pkg::PH_HIGH;
		assign prun[i] = run_q;

		always_comb begin
			ph_d = ph_q;
			if (!go)
				ph_d = poci_pkg::PH_IDLE;
			else begin
				case (ph_q)
					poci_pkg::PH_IDLE: ph_d = poci_pkg::PH_HIGH;
					poci_pkg::PH_HIGH: if (last) ph_d = poci_pkg::PH_LOW;
					poci_pkg::PH_LOW:  if (last)
						ph_d = fin ? poci_pkg::PH_IDLE : poci_pkg::PH_HIGH;
					default: ph_d = poci_pkg::PH_IDLE;
				endcase
			end
		end

		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				ph_q    <= poci_pkg::PH_IDLE;
				run_q   <= 1'b0;
				high_q  <= poci_pkg::RST_WIDTH;
				low_q   <= poci_pkg::RST_WIDTH;
				total_q <= poci_pkg::RST_TOTAL;
				pre_q   <= 16'h0000;
				units_q <= 16'h0000;
				done_q  <= 32'h00000000;
			end else begin
				ph_q <= ph_d;
				// A master start in the finishing cycle wins
				if (bit_we)
					run_q <= acc_wdata[0];
				else if (prw_we)
					run_q <= acc_wdata[i];
				else if (fin)
					run_q <= 1'b0;
				if (hi_we)
					high_q <= acc_wdata;
				if (lo_we)
					low_q <= acc_wdata;
				if (thi_we)
					total_q[31:16] <= acc_wdata;
				if (tlo_we)
					total_q[15:0] <= acc_wdata;
				pre_q <= (ph_d != ph_q || tick) ? 16'h0000 : pre_q + 16'h0001;
				if (ph_d == poci_pkg::PH_HIGH && ph_q != poci_pkg::PH_HIGH)
					units_q <= hload;
				else if (ph_d == poci_pkg::PH_LOW && ph_q != poci_pkg::PH_LOW)
					units_q <= lload;
				else if (tick)
					units_q <= units_q - 16'h0001;
				if (ph_q == poci_pkg::PH_IDLE)
					done_q <= 32'h00000000;
				else if (ph_q == poci_pkg::PH_LOW && last)
					done_q <= done_n;
			end
		end
	end

	// Event counter channels
	for (genvar i = 0; i < 2; i++) begin : g_ct
		logic [31:0] cnt_q;
		logic        run_q, ovf_q;
		wire bit_we = cw && acc_addr == 16'(poci_pkg::C_CRUN + i);
		wire clr    = (cw && acc_addr == 16'(poci_pkg::C_CLR + i)
			&& acc_wdata[0]) || (clrw_we && acc_wdata[i]);
		wire chi_we = hw && acc_addr == 16'(poci_pkg::H_CNT + 2 * i);
		wire clo_we = hw && acc_addr == 16'(poci_pkg::H_CNT + 2 * i + 1);
		wire inc    = ifunc[i] && run_q && din_s_q[i] && !din_p_q[i];
		wire wrap   = inc && cnt_q == 32'hffffffff;
		assign crun[i] = run_q;
		assign ovf[i]  = ovf_q;

		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				cnt_q <= 32'h00000000;
				run_q <= 1'b0;
				ovf_q <= 1'b0;
			end else begin
				if (bit_we)
					run_q <= acc_wdata[0];
				else if (crw_we)
					run_q <= acc_wdata[i];
				if (chi_we)
					cnt_q[31:16] <= acc_wdata;
				else if (clo_we)
					cnt_q[15:0] <= acc_wdata;
				else if (inc)
					cnt_q <= cnt_q + 32'h00000001;
				// Set wins over a clear in the same cycle
				ovf_q <= wrap | (ovf_q & ~clr);
			end
		end
	end

	// Read selection
	wire [15:0] coil_v = {2'b00, prun, 2'b00, crun, ostate_q};
	wire [31:0] din_v  = {6'h00, ovf, ofunc, ifunc, din_s_q};
	wire [15:0] hold_v [16];
	wire [15:0] ireg_v [4];
	assign hold_v[0]  = g_ct[0].cnt_q[31:16];
	assign hold_v[1]  = g_ct[0].cnt_q[15:0];
	assign hold_v[2]  = g_ct[1].cnt_q[31:16];
	assign hold_v[3]  = g_ct[1].cnt_q[15:0];
	assign hold_v[4]  = {8'h00, ostate_q};
	assign hold_v[5]  = g_pl[0].total_q[31:16];
	assign hold_v[6]  = g_pl[0].total_q[15:0];
	assign hold_v[7]  = g_pl[1].total_q[31:16];
	assign hold_v[8]  = g_pl[1].total_q[15:0];
	assign hold_v[9]  = g_pl[0].high_q;
	assign hold_v[10] = g_pl[1].high_q;
	assign hold_v[11] = g_pl[0].low_q;
	assign hold_v[12] = g_pl[1].low_q;
	assign hold_v[13] = {14'h0000, prun};
	assign hold_v[14] = {14'h0000, crun};
	assign hold_v[15] = 16'h0000;
	assign ireg_v[0]  = {8'h00, din_s_q};
	assign ireg_v[1]  = {14'h0000, ovf};
	assign ireg_v[2]  = {8'h00, ifunc};
	assign ireg_v[3]  = {8'h00, ofunc};
	wire [15:0] rsel = sp_c ? {15'h0000, coil_v[acc_addr[3:0]]}
		: sp_d ? {15'h0000, din_v[acc_addr[4:0]]}
		: sp_h ? hold_v[acc_addr[3:0]] : ireg_v[acc_addr[1:0]];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ack_q   <= acc_req;
			err_q   <= acc_req && !ok;
			rdata_q <= (acc_req && !acc_we && ok) ? rsel : 16'h0000;
		end
	end

	assign dout      = dout_q;
	assign acc_ack   = ack_q;
	assign acc_err   = err_q;
	assign acc_rdata = rdata_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_ireg_rd0;
		acc_req && !acc_we && sp_i && acc_addr == poci_pkg::I_ISW;
	endsequence
	// A count word write in the wrap cycle wins over the wrapped value
	sequence s_ovf_wrap;
		g_ct[0].wrap && !g_ct[0].chi_we && !g_ct[0].clo_we;
	endsequence

	a_plain_out_follow: assert property (
		##1 dout_q[7] == $past(ostate_q[7]))
		else $error("plain output does not follow state bit");
	a_mode_write_refused: assert property (
		acc_req && acc_we && sp_d |=> acc_err && acc_ack)
		else $error("write to mode bits not refused");
	a_pulse_stop_idle: assert property (
		!g_pl[0].run_q |=> g_pl[0].ph_q == poci_pkg::PH_IDLE)
		else $error("pulse channel runs while stopped");
	a_pulse_high_out: assert property (
		ofunc[0] && g_pl[0].ph_q == poci_pkg::PH_HIGH |=> dout_q[0])
		else $error("pulse output not high in high phase");
	a_pulse_low_out: assert property (
		ofunc[0] && g_pl[0].ph_q == poci_pkg::PH_LOW |=> !dout_q[0])
		else $error("pulse output not low in low phase");
	a_pulse_total_end: assert property (
		g_pl[0].fin && !g_pl[0].bit_we && !prw_we
		|=> !g_pl[0].run_q ##1 g_pl[0].ph_q == poci_pkg::PH_IDLE)
		else $error("pulse train did not stop at total");
	a_input_state_read: assert property (
		s_ireg_rd0 |=> acc_rdata[7:0] == $past(din_s_q) && !acc_err)
		else $error("input state word mismatch");
	a_counter_pause_hold: assert property (
		!g_ct[0].run_q && !g_ct[0].chi_we && !g_ct[0].clo_we
		|=> $stable(g_ct[0].cnt_q))
		else $error("paused counter moved");
	a_counter_step_one: assert property (
		g_ct[0].inc && !g_ct[0].chi_we && !g_ct[0].clo_we
		|=> g_ct[0].cnt_q == $past(g_ct[0].cnt_q) + 32'h00000001)
		else $error("counter did not step by one");
	a_overflow_set: assert property (
		s_ovf_wrap |=> g_ct[0].ovf_q && g_ct[0].cnt_q == 32'h00000000)
		else $error("overflow flag not set on wrap");
	a_overflow_clear: assert property (
		g_ct[0].clr && !g_ct[0].wrap |=> !g_ct[0].ovf_q)
		else $error("overflow flag not cleared");
	a_word_write_all: assert property (
		osw_we |=> ostate_q == $past(acc_wdata[7:0])
		##1 dout_q[7:2] == $past(acc_wdata[7:2], 2))
		else $error("aggregate write did not reach all channels");
endmodule : poci_top
`default_nettype wire

// file: hw/poci_pkg.sv
// Constants for the pulse output and event counter channel block.
// Assumes one 10 MHz system clock; the map is indexed per access space.
package poci_pkg;
	localparam int unsigned N_IN          = 8;
	localparam int unsigned N_OUT         = 8;
	localparam int unsigned N_CNT         = 2;
	localparam int unsigned N_PLS         = 2;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned PULSE_UNIT_NS = 500000;
	localparam int unsigned UNIT_CYCLES   = PULSE_UNIT_NS / CLK_PERIOD_NS;

	// Access spaces
	localparam logic [1:0] SP_COIL = 2'h0;
	localparam logic [1:0] SP_DIN  = 2'h1;
	localparam logic [1:0] SP_HOLD = 2'h2;
	localparam logic [1:0] SP_IREG = 2'h3;

	// Coil space bit indexes
	localparam logic [15:0] C_OSTATE = 16'h0000;
	localparam logic [15:0] C_CRUN   = 16'h0008;
	localparam logic [15:0] C_CLR    = 16'h000a;
	localparam logic [15:0] C_PRUN   = 16'h000c;
	localparam logic [15:0] C_END    = 16'h000e;
	// Discrete input space bit indexes
	localparam logic [15:0] D_ISTATE = 16'h0000;
	localparam logic [15:0] D_IFUNC  = 16'h0008;
	localparam logic [15:0] D_OFUNC  = 16'h0010;
	localparam logic [15:0] D_OVF    = 16'h0018;
	localparam logic [15:0] D_END    = 16'h001a;
	// Holding register word indexes, double words high word first
	localparam logic [15:0] H_CNT    = 16'h0000;
	localparam logic [15:0] H_OSW    = 16'h0004;
	localparam logic [15:0] H_TOTAL  = 16'h0005;
	localparam logic [15:0] H_HIGH   = 16'h0009;
	localparam logic [15:0] H_LOW    = 16'h000b;
	localparam logic [15:0] H_PRUN   = 16'h000d;
	localparam logic [15:0] H_CRUN   = 16'h000e;
	localparam logic [15:0] H_CLR    = 16'h000f;
	localparam logic [15:0] H_END    = 16'h0010;
	// Input register word indexes
	localparam logic [15:0] I_ISW    = 16'h0000;
	localparam logic [15:0] I_OVFW   = 16'h0001;
	localparam logic [15:0] I_IFW    = 16'h0002;
	localparam logic [15:0] I_OFW    = 16'h0003;
	localparam logic [15:0] I_END    = 16'h0004;

	// Values after reset
	localparam logic [15:0] RST_WIDTH = 16'h0001;
	localparam logic [31:0] RST_TOTAL = 32'h00000000;

	typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW} poci_phase_t;
endpackage : poci_pkg

// file: test/poci_master.sv
// Remote master model that issues coil and register accesses.
// Assumes one request pulse per call and notes the answer it expects.
`timescale 1ns/1ps
`default_nettype none
module poci_master (
	input  wire logic        sys_clk,
	output var  logic        acc_req,
	output var  logic        acc_we,
	output var  logic [1:0]  acc_space,
	output var  logic [15:0] acc_addr,
	output var  logic [15:0] acc_wdata
);
	int          seed = 32'hf5fa8120;
	logic [16:0] exp_q[$];

	function automatic logic [15:0] rnd();
		return 16'($random(seed));
	endfunction : rnd

	initial begin
		acc_req   = 1'b0;
		acc_we    = 1'b0;
		acc_space = 2'h0;
		acc_addr  = 16'h0000;
		acc_wdata = 16'h0000;
	end

	// Expected answer is {err, rdata}
	task automatic acc(input logic we, input logic [1:0] sp,
		input logic [15:0] a, input logic [15:0] wd, input logic [16:0] ex);
		@(posedge sys_clk);
		acc_req   <= 1'b1;
		acc_we    <= we;
		acc_space <= sp;
		acc_addr  <= a;
		acc_wdata <= wd;
		exp_q.push_back(ex);
		@(posedge sys_clk);
		acc_req   <= 1'b0;
		// Idle address and data carry a changing pattern, not the last request
		acc_addr  <= rnd();
		acc_wdata <= rnd();
	endtask : acc
endmodule : poci_master
`default_nettype wire

// file: test/poci_top_tb_top.sv
// Self-checking bench for poci_top: access port, pins and pulse timing.
// Assumes the master model in poci_master and a short pulse unit.
`timescale 1ns/1ps
`default_nettype none
module poci_top_tb_top;
	localparam int UC = 4;
	logic        sys_clk, rstn, acc_req, acc_we, acc_ack, acc_err;
	logic [7:0]  din, dout;
	logic [1:0]  cfg_out_pulse, cfg_in_count, acc_space;
	logic [15:0] acc_addr, acc_wdata, acc_rdata, v;
	logic [16:0] ex;
	int          err_count = 0, n_compared = 0, n, p, hi, lo;

	poci_top #(.UNIT_CYCLES(UC)) uut (.sys_clk(sys_clk), .rstn(rstn),
		.din(din), .cfg_out_pulse(cfg_out_pulse),
		.cfg_in_count(cfg_in_count), .acc_req(acc_req), .acc_we(acc_we),
		.acc_space(acc_space), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .dout(dout), .acc_ack(acc_ack),
		.acc_err(acc_err), .acc_rdata(acc_rdata));
	poci_master u_m (.sys_clk(sys_clk), .acc_req(acc_req),
		.acc_we(acc_we), .acc_space(acc_space), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata));

	always #50 sys_clk = ~sys_clk;

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	task automatic wr(input logic [1:0] sp, input logic [15:0] a, d);
		u_m.acc(1'b1, sp, a, d, 17'h00000);
	endtask : wr
	task automatic rd(input logic [1:0] sp, input logic [15:0] a, e);
		u_m.acc(1'b0, sp, a, 16'h0000, {1'b0, e});
	endtask : rd
	task automatic bad(input logic we, input logic [1:0] sp,
		input logic [15:0] a);
		u_m.acc(we, sp, a, 16'h0001, 17'h10000);
	endtask : bad
	task automatic edges(input logic [7:0] m, input int k);
		repeat (k) begin
			din <= m;
			tick(4);
			din <= 8'h00;
			tick(4);
		end
	endtask : edges

	// Oldest noted answer against each acknowledge
	always @(negedge sys_clk) begin
		if (acc_ack === 1'b1) begin
			ex = (u_m.exp_q.size() > 0) ? u_m.exp_q.pop_front() : 17'h1dead;
			chk("acc_err", 16'(ex[16]), 16'(acc_err));
			chk("acc_rdata", ex[15:0], acc_rdata);
		end
	end

	initial begin
		#(100 * 20000);
		err_count++;
		$display("unexpected timeout expected done seen running");
		wrap_up();
	end

	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		din = 8'h00;
		cfg_out_pulse = 2'h0;
		cfg_in_count = 2'h0;
		tick(5);
		rstn <= 1'b1;
		rd(poci_pkg::SP_HOLD, poci_pkg::H_HIGH, 16'h0001);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_LOW + 16'h1, 16'h0001);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_TOTAL + 16'h1, 16'h0000);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_CNT + 16'h1, 16'h0000);
		$display("test reset done");
		v = u_m.rnd() & 16'h00ff;
		wr(poci_pkg::SP_HOLD, poci_pkg::H_OSW, v);
		tick(2);
		@(negedge sys_clk);
		chk("dout", v, {8'h00, dout});
		wr(poci_pkg::SP_COIL, poci_pkg::C_OSTATE + 16'h3, {15'h0, ~v[3]});
		rd(poci_pkg::SP_HOLD, poci_pkg::H_OSW, v ^ 16'h0008);
		rd(poci_pkg::SP_COIL, poci_pkg::C_OSTATE + 16'h3, {15'h0, ~v[3]});
		$display("test output state done");
		v = u_m.rnd();
		cfg_out_pulse <= v[1:0];
		cfg_in_count <= v[3:2];
		tick(1);
		rd(poci_pkg::SP_IREG, poci_pkg::I_OFW, {14'h0, v[1:0]});
		rd(poci_pkg::SP_IREG, poci_pkg::I_IFW, {14'h0, v[3:2]});
		rd(poci_pkg::SP_DIN, poci_pkg::D_OFUNC + 16'h1, {15'h0, v[1]});
		rd(poci_pkg::SP_DIN, poci_pkg::D_IFUNC, {15'h0, v[2]});
		bad(1'b1, poci_pkg::SP_DIN, poci_pkg::D_OFUNC);
		bad(1'b1, poci_pkg::SP_IREG, poci_pkg::I_IFW);
		$display("test modes done");
		cfg_in_count <= 2'h0;
		v = u_m.rnd();
		din <= v[7:0];
		tick(4);
		rd(poci_pkg::SP_IREG, poci_pkg::I_ISW, {8'h0, v[7:0]});
		rd(poci_pkg::SP_DIN, poci_pkg::D_ISTATE + 16'h7, {15'h0, v[7]});
		$display("test input state done");
		cfg_out_pulse <= 2'b01;
		wr(poci_pkg::SP_HOLD, poci_pkg::H_HIGH, 16'h0002);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_LOW, 16'h0003);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_TOTAL + 16'h1, 16'h0002);
		wr(poci_pkg::SP_COIL, poci_pkg::C_PRUN, 16'h0001);
		n = 0;
		while (dout[0] !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		for (p = 0; p < 2; p++) begin
			hi = 0;
			lo = 0;
			while (dout[0] === 1'b1 && hi < 100) begin
				@(negedge sys_clk);
				hi++;
			end
			while (dout[0] === 1'b0 && lo < 100) begin
				@(negedge sys_clk);
				lo++;
			end
			chk("high cycles", 16'(hi), 16'(2 * UC));
			chk("low cycles", 16'(lo), 16'((p == 0) ? 3 * UC : 100));
		end
		rd(poci_pkg::SP_COIL, poci_pkg::C_PRUN, 16'h0000);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_TOTAL + 16'h1, 16'h0000);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_PRUN, 16'h0001);
		tick(5);
		hi = 0;
		repeat (100) @(negedge sys_clk) hi += (dout[0] === 1'b1);
		// 100 cycles hold five whole periods of two high and three low units
		chk("free run highs", 16'(hi), 16'(100 / (5 * UC) * 2 * UC));
		wr(poci_pkg::SP_COIL, poci_pkg::C_PRUN, 16'h0000);
		tick(3);
		hi = 0;
		repeat (40) @(negedge sys_clk) hi += (dout[0] !== 1'b0);
		chk("stopped highs", 16'(hi), 16'h0000);
		tick(1);
		$display("test pulse done");
		cfg_in_count <= 2'b01;
		din <= 8'h00;
		wr(poci_pkg::SP_HOLD, poci_pkg::H_CNT, 16'hffff);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_CNT + 16'h1, 16'hfffe);
		wr(poci_pkg::SP_COIL, poci_pkg::C_CRUN, 16'h0001);
		edges(8'h03, 3);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_CNT, 16'h0000);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_CNT + 16'h1, 16'h0001);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_CNT + 16'h3, 16'h0000);
		rd(poci_pkg::SP_DIN, poci_pkg::D_OVF, 16'h0001);
		rd(poci_pkg::SP_IREG, poci_pkg::I_OVFW, 16'h0001);
		wr(poci_pkg::SP_COIL, poci_pkg::C_CLR, 16'h0001);
		rd(poci_pkg::SP_DIN, poci_pkg::D_OVF, 16'h0000);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_CRUN, 16'h0000);
		edges(8'h01, 2);
		rd(poci_pkg::SP_HOLD, poci_pkg::H_CNT + 16'h1, 16'h0001);
		rd(poci_pkg::SP_COIL, poci_pkg::C_CRUN, 16'h0000);
		// Second wrap, cleared through the aggregate clear word
		wr(poci_pkg::SP_HOLD, poci_pkg::H_CNT, 16'hffff);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_CNT + 16'h1, 16'hffff);
		wr(poci_pkg::SP_COIL, poci_pkg::C_CRUN, 16'h0001);
		edges(8'h01, 1);
		rd(poci_pkg::SP_IREG, poci_pkg::I_OVFW, 16'h0001);
		wr(poci_pkg::SP_HOLD, poci_pkg::H_CLR, 16'h0001);
		rd(poci_pkg::SP_IREG, poci_pkg::I_OVFW, 16'h0000);
		$display("test counter done");
		bad(1'b0, poci_pkg::SP_COIL, poci_pkg::C_END);
		bad(1'b0, poci_pkg::SP_DIN, poci_pkg::D_END);
		bad(1'b1, poci_pkg::SP_HOLD, poci_pkg::H_END);
		bad(1'b0, poci_pkg::SP_IREG, poci_pkg::I_END);
		tick(4);
		chk("pending answers", 16'(u_m.exp_q.size()), 16'h0000);
		$display("test unmapped done");
		wrap_up();
	end
endmodule : poci_top_tb_top
`default_nettype wire
